// File: hw/rpu_pkg.sv
package rpu_pkg;
    localparam int RPU_NUM_REGIONS = 8;
    localparam int RPU_AW = 32;
    localparam int RPU_RIDX_W = 3;
    // Region registers: three words per region in a 16-byte slot, base at 0x000
    localparam logic [11:0] RPU_REG_REGION_BASE = 12'h000;
    localparam logic [11:0] RPU_OFF_BASE = 12'h000;
    localparam logic [11:0] RPU_OFF_LIMIT = 12'h004;
    localparam logic [11:0] RPU_OFF_ATTR = 12'h008;
    localparam logic [11:0] RPU_REG_CTRL = 12'h100;
    localparam logic [11:0] RPU_REG_BG_ATTR = 12'h104;
    localparam logic [11:0] RPU_REG_FAULT_STAT = 12'h108;
    localparam logic [11:0] RPU_REG_FAULT_ADDR = 12'h10C;
    localparam logic [11:0] RPU_REG_ORDER_STAT = 12'h110;
    // Attribute word fields
    localparam int RPU_ATTR_EN = 0;
    localparam int RPU_ATTR_TYPE_LO = 1;
    localparam int RPU_ATTR_SHARE = 3;
    localparam int RPU_ATTR_XN = 4;
    localparam int RPU_ATTR_W = 5;
    // Control fields
    localparam int RPU_CTRL_EN = 0;
    localparam int RPU_CTRL_BG_EN = 1;
    // Fault status fields
    localparam int RPU_FS_NOMATCH = 0;
    localparam int RPU_FS_XN = 1;
    localparam int RPU_FS_WR = 2;
    localparam logic [RPU_ATTR_W-1:0] RPU_ATTR_RESET = 5'h00;
    localparam logic [RPU_ATTR_W-1:0] RPU_BG_RESET = 5'h00;
    localparam logic [31:0] RPU_ZERO32 = 32'h00000000;

    typedef enum logic [1:0] {
        RPU_MT_NORMAL = 2'h0,
        RPU_MT_DEVICE = 2'h1,
        RPU_MT_STRONG = 2'h2
    } rpu_mtype_t;
endpackage : rpu_pkg

// File: hw/rpu_region_match.sv
`timescale 1ns/1ps
module rpu_region_match
    import rpu_pkg::*;
#(
    parameter int NREG = RPU_NUM_REGIONS,
    parameter int AW = RPU_AW
) (
    input wire logic [AW-1:0] addr,
    input wire logic [NREG*AW-1:0] base_flat,
    input wire logic [NREG*AW-1:0] limit_flat,
    input wire logic [NREG-1:0] en,
    output logic hit,
    output logic [RPU_RIDX_W-1:0] idx
);
    logic [NREG-1:0] hit_vec;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_cmp
            assign hit_vec[g] = en[g] && (addr >= base_flat[g*AW +: AW]) && (addr <= limit_flat[g*AW +: AW]);
        end
    endgenerate

    // Highest numbered region wins on overlap, so later regions can carve holes
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < NREG; i++) begin
            if (hit_vec[i]) begin
                hit = 1'b1;
                idx = RPU_RIDX_W'(i);
            end
        end
    end
endmodule : rpu_region_match

// File: hw/rpu_top.sv
// Overview of operation
// - Eight programmable regions plus an optional enabled background region.
// - Matched region's type and attributes decide how each access is handled.
// - Normal memory accesses may reorder and issue speculative reads.
// - Device accesses keep order against other device and strongly-ordered accesses.
// - Strongly-ordered accesses keep order against every other access.
// - Device writes may be buffered; strongly-ordered writes never are.
// - Shareable regions request coherent handling from the memory system.
// - Strongly-ordered regions are always treated as shareable.
// - No-execute blocks fetches; fault only when such an instruction executes.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module rpu_top
    import rpu_pkg::*;
#(
    parameter int NREG = RPU_NUM_REGIONS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic acc_exec,
    input wire logic acc_spec,
    output logic acc_ready,
    output logic rsp_valid,
    output logic rsp_allow,
    output logic rsp_fault,
    output logic [1:0] rsp_mtype,
    output logic rsp_shareable,
    output logic rsp_no_execute_attr,
    output logic rsp_may_reorder,
    output logic rsp_may_speculate,
    output logic rsp_may_buffer,
    output logic rsp_order_dev,
    output logic rsp_order_all,
    input wire logic ordered_busy
);
    logic [NREG*32-1:0] base_q, base_d, limit_q, limit_d;
    logic [NREG*RPU_ATTR_W-1:0] attr_q, attr_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [RPU_ATTR_W-1:0] bg_q, bg_d;
    logic [2:0] fstat_q, fstat_d;
    logic [31:0] faddr_q, faddr_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [NREG-1:0] en_vec;
    logic hit;
    logic [RPU_RIDX_W-1:0] hidx;

    // Response registers
    logic rv_q, rv_d, ra_q, ra_d, rf_q, rf_d;
    logic [1:0] rt_q, rt_d;
    logic rs_q, rs_d, rx_q, rx_d, rro_q, rro_d, rsp_q, rsp_d, rb_q, rb_d, rod_q, rod_d, roa_q, roa_d;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_en
            assign en_vec[g] = attr_q[g*RPU_ATTR_W + RPU_ATTR_EN];
        end
    endgenerate

    rpu_region_match #(.NREG(NREG), .AW(RPU_AW)) u_match (
        .addr(acc_addr),
        .base_flat(base_q),
        .limit_flat(limit_q),
        .en(en_vec),
        .hit(hit),
        .idx(hidx)
    );

    // APB register file: zero-wait, error on unmapped offsets
    wire apb_acc = psel && penable;
    wire [11:0] rsel = paddr - RPU_REG_REGION_BASE;
    wire reg_region = (paddr < RPU_REG_CTRL) && (paddr[11:4] < 8'(NREG)) && (paddr[3:2] != 2'h3);
    wire [RPU_RIDX_W-1:0] ridx = rsel[4+RPU_RIDX_W-1:4];
    wire [11:0] roff = {8'h00, rsel[3:0]};

    // Access classification from matched region or background
    logic [RPU_ATTR_W-1:0] sel_attr;
    logic matched, in_bg, no_exec, mt_strong, mt_dev, xn_fault, nomatch_fault;
    always_comb begin
        sel_attr = attr_q[hidx*RPU_ATTR_W +: RPU_ATTR_W];
        matched = 1'b1;
        if (!ctrl_q[RPU_CTRL_EN]) begin
            sel_attr = bg_q;
        end else if (!hit) begin
            sel_attr = bg_q;
            matched = ctrl_q[RPU_CTRL_BG_EN];
        end
    end
    assign in_bg = !hit;
    assign mt_strong = sel_attr[RPU_ATTR_TYPE_LO +: 2] == RPU_MT_STRONG;
    assign mt_dev = sel_attr[RPU_ATTR_TYPE_LO +: 2] == RPU_MT_DEVICE;
    assign no_exec = sel_attr[RPU_ATTR_XN];
    // Fetches of no-execute code pass as denied data; only execution faults
    assign xn_fault = acc_exec && no_exec && matched;
    assign nomatch_fault = !matched;
    // Speculation only reaches normal memory; elsewhere it is refused quietly, never faulted
    wire spec_block = acc_spec && (mt_strong || mt_dev);

    // Ordered types stall while the memory side still has ordered work pending
    assign acc_ready = !(ordered_busy && (mt_strong || mt_dev)) || !matched;

    always_comb begin
        base_d = base_q;
        limit_d = limit_q;
        attr_d = attr_q;
        ctrl_d = ctrl_q;
        bg_d = bg_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d = RPU_ZERO32;
            if (reg_region) begin
                unique case (roff)
                    RPU_OFF_BASE: prdata_d = base_q[ridx*32 +: 32];
                    RPU_OFF_LIMIT: prdata_d = limit_q[ridx*32 +: 32];
                    default: prdata_d = {27'h0000000, attr_q[ridx*RPU_ATTR_W +: RPU_ATTR_W]};
                endcase
            end else if (paddr == RPU_REG_CTRL) begin
                prdata_d = {30'h00000000, ctrl_q};
            end else if (paddr == RPU_REG_BG_ATTR) begin
                prdata_d = {27'h0000000, bg_q};
            end else if (paddr == RPU_REG_FAULT_STAT) begin
                prdata_d = {29'h00000000, fstat_q};
            end else if (paddr == RPU_REG_FAULT_ADDR) begin
                prdata_d = faddr_q;
            end else if (paddr == RPU_REG_ORDER_STAT) begin
                prdata_d = {31'h00000000, ordered_busy};
            end else begin
                pslverr_d = 1'b1;
            end
        end else if (apb_acc) begin
            pslverr_d = pslverr_q;
            // Writes commit only in the access phase, since pready is tied high
            if (pwrite && reg_region) begin
                unique case (roff)
                    RPU_OFF_BASE: base_d[ridx*32 +: 32] = pwdata;
                    RPU_OFF_LIMIT: limit_d[ridx*32 +: 32] = pwdata;
                    default: attr_d[ridx*RPU_ATTR_W +: RPU_ATTR_W] = pwdata[RPU_ATTR_W-1:0];
                endcase
            end else if (pwrite && paddr == RPU_REG_CTRL) begin
                ctrl_d = pwdata[1:0];
            end else if (pwrite && paddr == RPU_REG_BG_ATTR) begin
                bg_d = pwdata[RPU_ATTR_W-1:0];
            end
        end
    end

    // Fault capture: new fault beats a software clear in the same cycle
    wire acc_take = acc_valid && acc_ready;
    wire fs_clr = apb_acc && pwrite && paddr == RPU_REG_FAULT_STAT;
    always_comb begin
        fstat_d = fstat_q;
        faddr_d = faddr_q;
        if (fs_clr) begin
            fstat_d = fstat_q & ~pwdata[2:0];
        end
        if (acc_take && (xn_fault || nomatch_fault)) begin
            fstat_d[RPU_FS_NOMATCH] = fstat_d[RPU_FS_NOMATCH] | nomatch_fault;
            fstat_d[RPU_FS_XN] = fstat_d[RPU_FS_XN] | xn_fault;
            fstat_d[RPU_FS_WR] = acc_write;
            faddr_d = acc_addr;
        end
    end

    always_comb begin
        rv_d = acc_take;
        ra_d = acc_take && matched && !(no_exec && (acc_fetch || acc_exec)) && !spec_block;
        rf_d = acc_take && (xn_fault || nomatch_fault);
        rt_d = sel_attr[RPU_ATTR_TYPE_LO +: 2];
        rs_d = sel_attr[RPU_ATTR_SHARE] || mt_strong;
        rx_d = no_exec;
        rro_d = !mt_strong && !mt_dev;
        rsp_d = !mt_strong && !mt_dev && matched;
        rb_d = acc_write && !mt_strong;
        rod_d = mt_dev;
        roa_d = mt_strong;
        if (!acc_take) begin
            rt_d = rt_q;
            rs_d = rs_q;
            rx_d = rx_q;
            rro_d = rro_q;
            rsp_d = rsp_q;
            rb_d = rb_q;
            rod_d = rod_q;
            roa_d = roa_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= '0;
            limit_q <= '0;
            attr_q <= {NREG{RPU_ATTR_RESET}};
            ctrl_q <= 2'h0;
            bg_q <= RPU_BG_RESET;
            fstat_q <= 3'h0;
            faddr_q <= RPU_ZERO32;
            prdata_q <= RPU_ZERO32;
            pslverr_q <= 1'b0;
            rv_q <= 1'b0;
            ra_q <= 1'b0;
            rf_q <= 1'b0;
            rt_q <= 2'h0;
            rs_q <= 1'b0;
            rx_q <= 1'b0;
            rro_q <= 1'b0;
            rsp_q <= 1'b0;
            rb_q <= 1'b0;
            rod_q <= 1'b0;
            roa_q <= 1'b0;
        end else begin
            base_q <= base_d;
            limit_q <= limit_d;
            attr_q <= attr_d;
            ctrl_q <= ctrl_d;
            bg_q <= bg_d;
            fstat_q <= fstat_d;
            faddr_q <= faddr_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            rv_q <= rv_d;
            ra_q <= ra_d;
            rf_q <= rf_d;
            rt_q <= rt_d;
            rs_q <= rs_d;
            rx_q <= rx_d;
            rro_q <= rro_d;
            rsp_q <= rsp_d;
            rb_q <= rb_d;
            rod_q <= rod_d;
            roa_q <= roa_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = apb_acc && pslverr_q;
    assign rsp_valid = rv_q;
    assign rsp_allow = ra_q;
    assign rsp_fault = rf_q;
    assign rsp_mtype = rt_q;
    assign rsp_shareable = rs_q;
    assign rsp_no_execute_attr = rx_q;
    assign rsp_may_reorder = rro_q;
    assign rsp_may_speculate = rsp_q;
    assign rsp_may_buffer = rb_q;
    assign rsp_order_dev = rod_q;
    assign rsp_order_all = roa_q;

    a_strong_share: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_valid && rsp_mtype == RPU_MT_STRONG |-> rsp_shareable && !rsp_may_buffer)
        else $error("strongly-ordered response not shareable or buffered");
    a_strong_nobuf: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && mt_strong |=> !rsp_may_buffer && rsp_order_all)
        else $error("strongly-ordered write buffered");
    a_normal_reorder: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && !mt_strong && !mt_dev |=> rsp_may_reorder && !rsp_order_dev && !rsp_order_all)
        else $error("normal access not reorderable");
    a_dev_order: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && mt_dev |=> rsp_order_dev && !rsp_may_reorder && !rsp_may_speculate)
        else $error("device access lost ordering");
    a_order_stall: assert property (@(posedge pclk) disable iff (!presetn)
        ordered_busy && matched && mt_strong |-> !acc_ready)
        else $error("strongly-ordered access passed busy path");
    a_xn_block: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && acc_fetch && !acc_exec && no_exec |=> !rsp_allow && !rsp_fault)
        else $error("no-execute fetch allowed or faulted");
    a_xn_fault: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && acc_exec && no_exec && matched |=> rsp_fault && fstat_q[RPU_FS_XN])
        else $error("no-execute execution did not fault");
    a_nomatch_fault: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && ctrl_q[RPU_CTRL_EN] && in_bg && !ctrl_q[RPU_CTRL_BG_EN]
        |=> rsp_fault && !rsp_allow && faddr_q == $past(acc_addr))
        else $error("unmatched access did not fault");
    a_type_pass: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take |=> rsp_valid && rsp_mtype == $past(sel_attr[RPU_ATTR_TYPE_LO +: 2]))
        else $error("response type differs from region type");
    a_share_pass: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && sel_attr[RPU_ATTR_SHARE] |=> rsp_shareable)
        else $error("shareable attribute dropped");
    a_share_clear: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && !sel_attr[RPU_ATTR_SHARE] && !mt_strong |=> !rsp_shareable)
        else $error("non-shareable region reported shareable");
    a_spec_block: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && spec_block |=> rsp_valid && !rsp_allow && !rsp_fault)
        else $error("speculative access to ordered memory allowed");
    a_dev_stall: assert property (@(posedge pclk) disable iff (!presetn)
        ordered_busy && matched && mt_dev |-> !acc_ready)
        else $error("device access passed busy path");
    a_bg_type: assert property (@(posedge pclk) disable iff (!presetn)
        acc_take && ctrl_q[RPU_CTRL_EN] && ctrl_q[RPU_CTRL_BG_EN] && in_bg
        |=> rsp_mtype == $past(bg_q[RPU_ATTR_TYPE_LO +: 2]))
        else $error("background access took wrong type");
endmodule : rpu_top

// File: tb/rpu_mem_model.sv
`timescale 1ns/1ps
module rpu_mem_model #(
    parameter int HOLD = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rsp_valid,
    input wire logic rsp_order_dev,
    input wire logic rsp_order_all,
    input wire logic stall,
    output logic ordered_busy
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // Ordered traffic stays in flight a while, so the core side really has to wait
    always_comb begin
        cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
        if (rsp_valid && (rsp_order_dev || rsp_order_all)) begin
            cnt_d = 4'(HOLD);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign ordered_busy = stall || (cnt_q != 4'h0);
endmodule : rpu_mem_model

// File: tb/rpu_top_bench.sv
`timescale 1ns/1ps
module rpu_top_bench;
    import rpu_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, acc_addr = 32'h00000000, rd;
    logic acc_valid = 1'b0, acc_write = 1'b0, acc_fetch = 1'b0, acc_exec = 1'b0, acc_spec = 1'b0, stall = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, acc_ready, rsp_valid, rsp_allow, rsp_fault, rsp_shareable, rsp_no_execute_attr;
    logic rsp_may_reorder, rsp_may_speculate, rsp_may_buffer, rsp_order_dev, rsp_order_all, ordered_busy, err;
    logic [1:0] rsp_mtype;
    int fails = 0, samples_checked = 0, cycles = 0;
    rpu_top i_rpu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_fetch(acc_fetch),
        .acc_exec(acc_exec), .acc_spec(acc_spec), .acc_ready(acc_ready), .rsp_valid(rsp_valid),
        .rsp_allow(rsp_allow), .rsp_fault(rsp_fault), .rsp_mtype(rsp_mtype), .rsp_shareable(rsp_shareable),
        .rsp_no_execute_attr(rsp_no_execute_attr), .rsp_may_reorder(rsp_may_reorder),
        .rsp_may_speculate(rsp_may_speculate), .rsp_may_buffer(rsp_may_buffer), .rsp_order_dev(rsp_order_dev),
        .rsp_order_all(rsp_order_all), .ordered_busy(ordered_busy));
    rpu_mem_model i_rpu_mem_model (.pclk(pclk), .presetn(presetn), .rsp_valid(rsp_valid),
        .rsp_order_dev(rsp_order_dev), .rsp_order_all(rsp_order_all), .stall(stall), .ordered_busy(ordered_busy));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Request is held until the edge where pready is seen high; data taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic acc(input logic [31:0] a, input logic wr, input logic f, input logic x);
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_write <= wr;
        acc_fetch <= f;
        acc_exec <= x;
        @(posedge pclk);
        while (acc_ready !== 1'b1) @(posedge pclk);
        acc_valid <= 1'b0;
        #1;
        chk({31'h0, rsp_valid}, 32'h1);
    endtask : acc
    // Compares allow, fault, type, shareable and no-execute
    task automatic rsp(input logic [5:0] exp);
        chk({26'h0, rsp_allow, rsp_fault, rsp_mtype, rsp_shareable, rsp_no_execute_attr}, {26'h0, exp});
    endtask : rsp
    task automatic t_reset_and_bus();
        apb(1'b0, RPU_REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({31'h0, err}, 32'h1);
        acc(32'h00001000, 1'b0, 1'b0, 1'b0);
        rsp(6'h20);
    endtask : t_reset_and_bus
    task automatic t_types();
        apb(1'b1, 12'h000, 32'h00001000);
        apb(1'b1, 12'h004, 32'h00001FFF);
        apb(1'b1, 12'h008, 32'h00000001);
        apb(1'b1, 12'h010, 32'h00002000);
        apb(1'b1, 12'h014, 32'h00002FFF);
        apb(1'b1, 12'h018, 32'h00000003);
        apb(1'b1, 12'h020, 32'h00003000);
        apb(1'b1, 12'h024, 32'h00003FFF);
        apb(1'b1, 12'h028, 32'h00000005);
        apb(1'b1, 12'h030, 32'h00005000);
        apb(1'b1, 12'h034, 32'h00005FFF);
        apb(1'b1, 12'h038, 32'h0000000B);
        apb(1'b1, 12'h070, 32'h00004000);
        apb(1'b1, 12'h074, 32'h00004FFF);
        apb(1'b1, 12'h078, 32'h00000011);
        apb(1'b1, RPU_REG_CTRL, 32'h1);
        acc(32'h00001FFF, 1'b0, 1'b0, 1'b0);
        rsp(6'h20);
        chk({30'h0, rsp_may_reorder, rsp_may_speculate}, 32'h3);
        acc(32'h00002000, 1'b1, 1'b0, 1'b0);
        rsp(6'h24);
        chk({30'h0, rsp_order_dev, rsp_order_all}, 32'h2);
        chk({31'h0, rsp_may_reorder}, 32'h0);
        chk({31'h0, rsp_may_buffer}, 32'h1);
        @(posedge pclk);
        acc_spec <= 1'b1;
        acc(32'h00002004, 1'b0, 1'b0, 1'b0);
        rsp(6'h04);
        @(posedge pclk);
        acc_spec <= 1'b0;
        acc(32'h00003004, 1'b1, 1'b0, 1'b0);
        rsp(6'h2A);
        chk({29'h0, rsp_may_buffer, rsp_order_all, rsp_may_reorder}, 32'h2);
        acc(32'h00005000, 1'b1, 1'b0, 1'b0);
        rsp(6'h26);
    endtask : t_types
    task automatic t_no_exec();
        acc(32'h00004010, 1'b0, 1'b1, 1'b0);
        rsp(6'h01);
        acc(32'h00004010, 1'b0, 1'b0, 1'b1);
        chk({30'h0, rsp_allow, rsp_fault}, 32'h1);
        apb(1'b0, RPU_REG_FAULT_STAT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, RPU_REG_FAULT_STAT, 32'h7);
    endtask : t_no_exec
    task automatic t_nomatch_bg();
        acc(32'h00008000, 1'b1, 1'b0, 1'b0);
        chk({30'h0, rsp_allow, rsp_fault}, 32'h1);
        apb(1'b0, RPU_REG_FAULT_STAT, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, RPU_REG_FAULT_ADDR, 32'h0);
        chk(rd, 32'h00008000);
        apb(1'b1, RPU_REG_BG_ATTR, 32'h00000005);
        apb(1'b1, RPU_REG_CTRL, 32'h3);
        acc(32'h00008000, 1'b0, 1'b0, 1'b0);
        rsp(6'h2A);
    endtask : t_nomatch_bg
    task automatic t_ordered_stall();
        @(posedge pclk);
        stall <= 1'b1;
        acc_valid <= 1'b1;
        acc_addr <= 32'h00002010;
        acc_write <= 1'b0;
        acc_fetch <= 1'b0;
        acc_exec <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, acc_ready}, 32'h0);
        chk({31'h0, rsp_valid}, 32'h0);
        @(posedge pclk);
        stall <= 1'b0;
        @(posedge pclk);
        while (acc_ready !== 1'b1) @(posedge pclk);
        acc_valid <= 1'b0;
        #1;
        chk({31'h0, rsp_valid}, 32'h1);
        rsp(6'h24);
        @(posedge pclk);
        stall <= 1'b1;
        acc(32'h00001010, 1'b0, 1'b0, 1'b0);
        rsp(6'h20);
        @(posedge pclk);
        stall <= 1'b0;
        acc(32'h00003010, 1'b0, 1'b0, 1'b0);
        rsp(6'h2A);
    endtask : t_ordered_stall
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_bus();
        t_types();
        t_no_exec();
        t_nomatch_bg();
        t_ordered_stall();
        repeat (4) @(posedge pclk);
        summarize();
    end
endmodule : rpu_top_bench
